// ---- shared/rf_pkg.sv ----
// Purpose: Shared constants and types for the banked processor register file.
// Assumes: 32-bit data path, sixteen architectural general registers.
// Notes:   Status layout kept to the mode bits, block bit, mask bits and flag bits only.
package rf_pkg;
    localparam int          DATA_W        = 32;       // Register width
    localparam int          GPR_COUNT     = 16;       // Architectural general registers
    localparam int          BANKED_COUNT  = 8;        // Registers duplicated per bank
    localparam int          PHYS_COUNT    = 24;       // Two banks plus the shared upper eight
    localparam int          PHYS_IDX_W    = 5;        // Width of a physical index
    localparam int          MD_BIT        = 30;       // Privileged mode bit
    localparam int          RB_BIT        = 29;       // Bank select bit
    localparam int          BL_BIT        = 28;       // Block bit
    localparam logic [31:0] SR_RESET      = 32'h7000_00f0; // Mode bits, block bit, mask set
    localparam logic [31:0] SR_VALID_MASK = 32'h7000_03f3; // Reserved bits stay zero
    localparam logic [31:0] VBR_RESET     = 32'h0000_0000; // Vector base after reset
    localparam logic [31:0] GBR_RESET     = 32'h0000_0000; // Undefined value, zero chosen
    localparam logic [31:0] ZERO_WORD     = 32'h0000_0000; // Cleared word
    localparam logic [4:0]  BANK1_R0_IDX  = 5'h08;    // Physical slot of bank one register zero
    localparam logic [4:0]  BANK0_R0_IDX  = 5'h00;    // Physical slot of bank zero register zero

    // System register selector
    typedef enum logic [1:0] {
        SYS_MAC_HIGH = 2'h0,
        SYS_MAC_LOW  = 2'h1,
        SYS_PROC_RET = 2'h2,
        SYS_PROG_CNT = 2'h3
    } sys_sel_t;

    // Control register selector; codes 8 to 15 reach the other bank
    typedef enum logic [3:0] {
        CTL_STATUS     = 4'h0,
        CTL_SAVED_STAT = 4'h1,
        CTL_SAVED_RET  = 4'h2,
        CTL_GLOBAL     = 4'h3,
        CTL_VECTOR     = 4'h4,
        CTL_ALT_R0     = 4'h8
    } ctl_sel_t;
endpackage

// ---- rtl/gpr_bank_map.sv ----
// Purpose: Map an architectural general register number to its physical slot.
// Assumes: Slots 0-7 bank zero, 8-15 bank one, 16-23 shared registers 8-15.
// Notes:   Purely combinational; the caller registers what it reads.
`timescale 1ns/1ps
module gpr_bank_map (
    // Register request
    input  wire logic [3:0] i_reg,
    input  wire logic       i_md,
    input  wire logic       i_rb,
    input  wire logic       i_alt,
    // Physical slot
    output logic      [4:0] o_index
);
    logic active_bank;   // Bank seen as general registers
    logic bank;          // Bank actually reached

    // User mode always sees bank zero; the alternate request flips it
    always_comb begin
        active_bank = i_md & i_rb;
        bank        = i_alt ? ~active_bank : active_bank;
        if (i_reg[3]) begin
            o_index = {2'b10, i_reg[2:0]};
        end else begin
            o_index = {1'b0, bank, i_reg[2:0]};
        end
    end
endmodule

// ---- rtl/cpu_banked_register_file.sv ----
// Purpose: Banked general, system and control registers of the core.
// Assumes: Decoder and exception logic drive the ports on I_MCLK.
// Notes:   Reads are registered, one cycle; a read sees the state before a
//          write in the same cycle.
`timescale 1ns/1ps
module cpu_banked_register_file
    import rf_pkg::*;
(
    // Clock and reset
    input  wire logic             I_MCLK,
    input  wire logic             I_ARST_N,
    // General register operands
    input  wire logic       [3:0] I_RD_A_ADDR,
    input  wire logic       [3:0] I_RD_B_ADDR,
    input  wire logic             I_GPR_WE,
    input  wire logic       [3:0] I_GPR_WADDR,
    input  wire logic      [31:0] I_GPR_WDATA,
    input  wire logic             I_R0_ONLY,
    output logic           [31:0] O_RD_A_DATA,
    output logic           [31:0] O_RD_B_DATA,
    output logic           [31:0] O_INDEX_R0,
    // System register transfers
    input  wire rf_pkg::sys_sel_t I_SYS_SEL,
    input  wire logic             I_SYS_WE,
    input  wire logic      [31:0] I_SYS_WDATA,
    output logic           [31:0] O_SYS_RDATA,
    // Program counter advance
    input  wire logic             I_PC_WE,
    input  wire logic      [31:0] I_PC_NEXT,
    // Control register transfers
    input  wire rf_pkg::ctl_sel_t I_CTL_SEL,
    input  wire logic             I_CTL_WE,
    input  wire logic             I_CTL_RE,
    input  wire logic      [31:0] I_CTL_WDATA,
    output logic           [31:0] O_CTL_RDATA,
    output logic                  O_PRIV_FAULT,
    // Exception entry and return
    input  wire logic             I_EXC_TAKE,
    input  wire logic      [31:0] I_EXC_SR,
    input  wire logic      [31:0] I_EXC_PC,
    input  wire logic             I_EXC_RETURN,
    // Architectural state view
    output logic           [31:0] O_PC,
    output logic           [31:0] O_STATUS,
    output logic           [31:0] O_VBR,
    output logic           [31:0] O_GBR
);
    import rf_pkg::*;

    // Whole block state in one record
    typedef struct packed {
        logic [PHYS_COUNT-1:0][DATA_W-1:0] gpr;  // Physical general registers
        logic [DATA_W-1:0] multiply_accum_high;                 // Multiply-accumulate high
        logic [DATA_W-1:0] multiply_accum_low;                 // Multiply-accumulate low
        logic [DATA_W-1:0] pr;                   // Procedure return register
        logic [DATA_W-1:0] pc;                   // Program counter
        logic [DATA_W-1:0] sr;                   // Status word
        logic [DATA_W-1:0] saved_status_word;                  // Saved status word
        logic [DATA_W-1:0] saved_return_pointer;                  // Saved return pointer
        logic [DATA_W-1:0] global_base_pointer;                  // Global base pointer
        logic [DATA_W-1:0] vector_base_pointer;                  // Vector base pointer
        logic [DATA_W-1:0] rd_a;                 // Operand A read data
        logic [DATA_W-1:0] rd_b;                 // Operand B read data
        logic [DATA_W-1:0] idx_r0;               // Index register value
        logic [DATA_W-1:0] sys_rd;               // System read data
        logic [DATA_W-1:0] ctl_rd;               // Control read data
        logic              fault;                // Refused access pulse
    } rf_state_t;

    rf_state_t  st;        // Registered state
    rf_state_t  next_st;   // Next state
    logic       priv;      // Privileged mode
    logic       bank_sel;  // Bank select bit
    logic [3:0] a_reg;     // Operand A after the zero-only override
    logic [3:0] w_reg;     // Write target after the zero-only override
    logic [4:0] a_idx;     // Physical slot of operand A
    logic [4:0] b_idx;     // Physical slot of operand B
    logic [4:0] w_idx;     // Physical slot of the write
    logic [4:0] r0_idx;    // Physical slot of active register zero
    logic [4:0] alt_idx;   // Physical slot in the other bank
    logic       ctl_ok;    // Control access allowed
    logic       ctl_alt;   // Control selector names the other bank

    assign priv     = st.sr[MD_BIT];
    assign bank_sel = st.sr[RB_BIT];
    // Zero-only slots ignore the port A and write address fields
    assign a_reg    = I_R0_ONLY ? 4'h0 : I_RD_A_ADDR;
    assign w_reg    = I_R0_ONLY ? 4'h0 : I_GPR_WADDR;
    assign ctl_alt  = I_CTL_SEL[3];
    // Only the global base is open to user mode
    assign ctl_ok   = priv || (I_CTL_SEL == CTL_GLOBAL);

    // Slot mapping for each access path
    gpr_bank_map u_map_a (.i_reg(a_reg), .i_md(priv), .i_rb(bank_sel), .i_alt(1'b0),
                          .o_index(a_idx));
    gpr_bank_map u_map_b (.i_reg(I_RD_B_ADDR), .i_md(priv), .i_rb(bank_sel),
                          .i_alt(1'b0), .o_index(b_idx));
    gpr_bank_map u_map_w (.i_reg(w_reg), .i_md(priv), .i_rb(bank_sel), .i_alt(1'b0),
                          .o_index(w_idx));
    gpr_bank_map u_map_r0 (.i_reg(4'h0), .i_md(priv), .i_rb(bank_sel), .i_alt(1'b0),
                           .o_index(r0_idx));
    gpr_bank_map u_map_alt (.i_reg({1'b0, I_CTL_SEL[2:0]}), .i_md(priv), .i_rb(bank_sel),
                            .i_alt(1'b1), .o_index(alt_idx));

    // Next-state logic; exception and return are applied last so they win
    always_comb begin
        next_st       = st;
        next_st.fault = 1'b0;
        // Operand reads and the index value
        next_st.rd_a   = st.gpr[a_idx];
        next_st.rd_b   = st.gpr[b_idx];
        next_st.idx_r0 = st.gpr[r0_idx];
        if (I_GPR_WE) begin
            next_st.gpr[w_idx] = I_GPR_WDATA;
        end
        // System register reads and writes
        case (I_SYS_SEL)
            SYS_MAC_HIGH: next_st.sys_rd = st.multiply_accum_high;
            SYS_MAC_LOW:  next_st.sys_rd = st.multiply_accum_low;
            SYS_PROC_RET: next_st.sys_rd = st.pr;
            default:      next_st.sys_rd = st.pc;
        endcase
        if (I_PC_WE) begin
            next_st.pc = I_PC_NEXT;
        end
        if (I_SYS_WE) begin
            case (I_SYS_SEL)
                SYS_MAC_HIGH: next_st.multiply_accum_high = I_SYS_WDATA;
                SYS_MAC_LOW:  next_st.multiply_accum_low = I_SYS_WDATA;
                SYS_PROC_RET: next_st.pr   = I_SYS_WDATA;
                default:      next_st.pc   = I_SYS_WDATA;
            endcase
        end
        // Control register reads; refused reads return zero
        next_st.ctl_rd = ZERO_WORD;
        if (ctl_ok) begin
            if (ctl_alt) begin
                next_st.ctl_rd = st.gpr[alt_idx];
            end else begin
                case (I_CTL_SEL)
                    CTL_STATUS:     next_st.ctl_rd = st.sr;
                    CTL_SAVED_STAT: next_st.ctl_rd = st.saved_status_word;
                    CTL_SAVED_RET:  next_st.ctl_rd = st.saved_return_pointer;
                    CTL_GLOBAL:     next_st.ctl_rd = st.global_base_pointer;
                    CTL_VECTOR:     next_st.ctl_rd = st.vector_base_pointer;
                    default:        next_st.ctl_rd = ZERO_WORD;
                endcase
            end
        end
        // User-mode access to a privileged register is dropped and flagged
        if ((I_CTL_WE || I_CTL_RE) && !ctl_ok) begin
            next_st.fault = 1'b1;
        end
        if (I_CTL_WE && ctl_ok) begin
            if (ctl_alt) begin
                next_st.gpr[alt_idx] = I_CTL_WDATA;
            end else begin
                case (I_CTL_SEL)
                    CTL_STATUS:     next_st.sr  = I_CTL_WDATA & SR_VALID_MASK;
                    CTL_SAVED_STAT: next_st.saved_status_word = I_CTL_WDATA;
                    CTL_SAVED_RET:  next_st.saved_return_pointer = I_CTL_WDATA;
                    CTL_GLOBAL:     next_st.global_base_pointer = I_CTL_WDATA;
                    CTL_VECTOR:     next_st.vector_base_pointer = I_CTL_WDATA;
                    default:        next_st.vector_base_pointer = st.vector_base_pointer;
                endcase
            end
        end
        // Saves take the old values, so the new status cannot leak into them
        if (I_EXC_TAKE) begin
            next_st.saved_return_pointer = st.pc;
            next_st.saved_status_word = st.sr;
            next_st.sr  = I_EXC_SR & SR_VALID_MASK;
            next_st.pc  = I_EXC_PC;
        end else if (I_EXC_RETURN) begin
            next_st.pc = st.saved_return_pointer;
            next_st.sr = st.saved_status_word & SR_VALID_MASK;
        end
    end

    // State register; general registers clear to zero for a defined start
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            st     <= '0;
            st.sr  <= SR_RESET;
            st.vector_base_pointer <= VBR_RESET;
            st.global_base_pointer <= GBR_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state record
    assign O_RD_A_DATA  = st.rd_a;
    assign O_RD_B_DATA  = st.rd_b;
    assign O_INDEX_R0   = st.idx_r0;
    assign O_SYS_RDATA  = st.sys_rd;
    assign O_CTL_RDATA  = st.ctl_rd;
    assign O_PRIV_FAULT = st.fault;
    assign O_PC         = st.pc;
    assign O_STATUS     = st.sr;
    assign O_VBR        = st.vector_base_pointer;
    assign O_GBR        = st.global_base_pointer;

    // Checks on the register file behaviour
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_ARST_N);

    property p_bank_one_read;
        (st.sr[MD_BIT] && st.sr[RB_BIT] && !I_R0_ONLY && I_RD_A_ADDR == 4'h0)
            |=> (O_RD_A_DATA == $past(st.gpr[BANK1_R0_IDX]));
    endproperty
    a_bank_one_read: assert property (p_bank_one_read)
        else $error("bank one not reached with bank bit set");

    property p_alt_bank_read;
        (st.sr[MD_BIT] && st.sr[RB_BIT] && I_CTL_SEL == CTL_ALT_R0)
            |=> (O_CTL_RDATA == $past(st.gpr[BANK0_R0_IDX]));
    endproperty
    a_alt_bank_read: assert property (p_alt_bank_read)
        else $error("other bank read returned wrong register");

    property p_zero_only;
        I_R0_ONLY |=> (O_RD_A_DATA == O_INDEX_R0);
    endproperty
    a_zero_only: assert property (p_zero_only)
        else $error("zero-only operand did not read register zero");

    property p_save_pc;
        I_EXC_TAKE |=> (st.saved_return_pointer == $past(st.pc)) && (O_PC == $past(I_EXC_PC));
    endproperty
    a_save_pc: assert property (p_save_pc)
        else $error("return pointer not saved on exception");

    property p_save_both;
        I_EXC_TAKE |=> (st.saved_status_word == $past(st.sr))
            && (O_STATUS == ($past(I_EXC_SR) & SR_VALID_MASK));
    endproperty
    a_save_both: assert property (p_save_both)
        else $error("status not saved before exception status applied");

    property p_return;
        (I_EXC_RETURN && !I_EXC_TAKE) |=> (O_PC == $past(st.saved_return_pointer));
    endproperty
    a_return: assert property (p_return)
        else $error("exception return did not reload program counter");

    property p_user_refused;
        (!st.sr[MD_BIT] && I_CTL_WE && I_CTL_SEL == CTL_VECTOR)
            |=> O_PRIV_FAULT && $stable(st.vector_base_pointer);
    endproperty
    a_user_refused: assert property (p_user_refused)
        else $error("user write to privileged register not refused");

    property p_user_global;
        (!st.sr[MD_BIT] && I_CTL_WE && I_CTL_SEL == CTL_GLOBAL)
            |=> !O_PRIV_FAULT && (O_GBR == $past(I_CTL_WDATA));
    endproperty
    a_user_global: assert property (p_user_global)
        else $error("user write to global base refused");

    property p_reserved_zero;
        (O_STATUS & ~SR_VALID_MASK) == ZERO_WORD;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved status bits set");

    property p_sys_write;
        (I_SYS_WE && I_SYS_SEL == SYS_MAC_LOW) ##1 (I_SYS_SEL == SYS_MAC_LOW)
            |=> (O_SYS_RDATA == $past(I_SYS_WDATA, 2));
    endproperty
    a_sys_write: assert property (p_sys_write)
        else $error("system register write not read back");

    c_exception:   cover property (I_EXC_TAKE ##[1:20] I_EXC_RETURN);
    c_user_fault:  cover property (O_PRIV_FAULT);
    c_bank_swap:   cover property (st.sr[RB_BIT] ##1 !st.sr[RB_BIT]);
    c_alt_write:   cover property (st.sr[MD_BIT] && I_CTL_WE && ctl_alt);
endmodule

// ---- test/cpu_decoder_model.sv ----
// Purpose: Stand-in for the decoder and exception logic that drive the register file.
// Assumes: Requests launch just after a rising edge and are taken at the next one.
// Notes:   Data lines are inverted once released so stale values never look valid.
`timescale 1ns/1ps
module cpu_decoder_model
    import rf_pkg::*;
(
    // Clock
    input  wire logic             i_mclk,
    // Operand and general write requests
    output logic            [3:0] o_rd_a_addr,
    output logic            [3:0] o_rd_b_addr,
    output logic                  o_gpr_we,
    output logic            [3:0] o_gpr_waddr,
    output logic           [31:0] o_gpr_wdata,
    output logic                  o_r0_only,
    // System and control transfers
    output rf_pkg::sys_sel_t      o_sys_sel,
    output logic                  o_sys_we,
    output logic           [31:0] o_sys_wdata,
    output rf_pkg::ctl_sel_t      o_ctl_sel,
    output logic                  o_ctl_we,
    output logic                  o_ctl_re,
    output logic           [31:0] o_ctl_wdata,
    // Exception entry and return
    output logic                  o_exc_take,
    output logic           [31:0] o_exc_sr,
    output logic           [31:0] o_exc_pc,
    output logic                  o_exc_return
);
    // Quiet values at time zero
    initial begin
        {o_rd_a_addr, o_rd_b_addr, o_gpr_we, o_gpr_waddr, o_r0_only} = '0;
        {o_sys_we, o_ctl_we, o_ctl_re, o_exc_take, o_exc_return} = '0;
        {o_gpr_wdata, o_sys_wdata, o_ctl_wdata, o_exc_sr, o_exc_pc} = '0;
        o_sys_sel = SYS_MAC_HIGH;
        o_ctl_sel = CTL_STATUS;
    end

    // Taken edge passes, strobes drop, released data turns to garbage
    task automatic fin();
        @(posedge i_mclk);
        {o_gpr_we, o_sys_we, o_ctl_we, o_ctl_re, o_exc_take, o_exc_return} <= '0;
        o_gpr_wdata <= ~o_gpr_wdata;
        o_sys_wdata <= ~o_sys_wdata;
        o_ctl_wdata <= ~o_ctl_wdata;
        #1;
    endtask

    // Operand read, optionally through the register-zero-only slot
    task automatic rd(input logic [3:0] a, input logic [3:0] b, input logic r0);
        @(posedge i_mclk);
        o_rd_a_addr <= a;
        o_rd_b_addr <= b;
        o_r0_only   <= r0;
        fin();
    endtask

    // General register write
    task automatic gpr_wr(input logic [3:0] a, input logic [31:0] d, input logic r0);
        @(posedge i_mclk);
        {o_gpr_we, o_gpr_waddr, o_gpr_wdata, o_r0_only} <= {1'b1, a, d, r0};
        fin();
    endtask

    // System register load; the read side follows the select
    task automatic sys_wr(input sys_sel_t s, input logic [31:0] d);
        @(posedge i_mclk);
        {o_sys_we, o_sys_wdata} <= {1'b1, d};
        o_sys_sel <= s;
        fin();
    endtask

    // Control register store (we=0) or load (we=1)
    task automatic ctl(input ctl_sel_t s, input logic we, input logic [31:0] d);
        @(posedge i_mclk);
        {o_ctl_re, o_ctl_we, o_ctl_wdata} <= {1'b1, we, d};
        o_ctl_sel <= s;
        fin();
    endtask

    // Exception entry with the status and handler address to apply
    task automatic exc_take(input logic [31:0] sr, input logic [31:0] pc);
        @(posedge i_mclk);
        {o_exc_take, o_exc_sr, o_exc_pc} <= {1'b1, sr, pc};
        fin();
    endtask

    // Return from exception
    task automatic exc_ret();
        @(posedge i_mclk);
        o_exc_return <= 1'b1;
        fin();
    endtask
endmodule

// ---- test/testbench.sv ----
// Purpose: Self-checking bench for the banked register file.
// Assumes: The decoder model issues every request; one request in flight.
// Notes:   Checks run 1 ns after the edge that answers, when outputs are settled.
`timescale 1ns/1ps
module testbench;
    import rf_pkg::*;
    logic I_MCLK = 1'b0;    // Core clock
    logic I_ARST_N = 1'b0;  // Reset, active low
    logic [3:0] I_RD_A_ADDR, I_RD_B_ADDR, I_GPR_WADDR;
    logic I_GPR_WE, I_R0_ONLY, I_SYS_WE, I_CTL_WE, I_CTL_RE, I_EXC_TAKE, I_EXC_RETURN;
    logic [31:0] I_GPR_WDATA, I_SYS_WDATA, I_CTL_WDATA, I_EXC_SR, I_EXC_PC;
    sys_sel_t I_SYS_SEL;    // System select
    ctl_sel_t I_CTL_SEL;    // Control select
    logic [31:0] O_RD_A_DATA, O_RD_B_DATA, O_INDEX_R0, O_SYS_RDATA, O_CTL_RDATA;
    logic [31:0] O_PC, O_STATUS, O_VBR, O_GBR;
    logic O_PRIV_FAULT;     // Refused access pulse
    int num_errors = 0;     // Mismatches
    int n_checks = 0;       // Comparisons
    int cycles = 0;         // Watchdog count

    always #5 I_MCLK = ~I_MCLK;

    cpu_decoder_model i_cpu_decoder_model (.i_mclk(I_MCLK), .o_rd_a_addr(I_RD_A_ADDR),
        .o_rd_b_addr(I_RD_B_ADDR), .o_gpr_we(I_GPR_WE), .o_gpr_waddr(I_GPR_WADDR),
        .o_gpr_wdata(I_GPR_WDATA), .o_r0_only(I_R0_ONLY), .o_sys_sel(I_SYS_SEL),
        .o_sys_we(I_SYS_WE), .o_sys_wdata(I_SYS_WDATA), .o_ctl_sel(I_CTL_SEL),
        .o_ctl_we(I_CTL_WE), .o_ctl_re(I_CTL_RE), .o_ctl_wdata(I_CTL_WDATA),
        .o_exc_take(I_EXC_TAKE), .o_exc_sr(I_EXC_SR), .o_exc_pc(I_EXC_PC),
        .o_exc_return(I_EXC_RETURN));

    // Program counter advance is left idle; the system path sets the counter
    cpu_banked_register_file i_cpu_banked_register_file (.I_MCLK(I_MCLK),
        .I_ARST_N(I_ARST_N), .I_RD_A_ADDR(I_RD_A_ADDR), .I_RD_B_ADDR(I_RD_B_ADDR),
        .I_GPR_WE(I_GPR_WE), .I_GPR_WADDR(I_GPR_WADDR), .I_GPR_WDATA(I_GPR_WDATA),
        .I_R0_ONLY(I_R0_ONLY), .O_RD_A_DATA(O_RD_A_DATA), .O_RD_B_DATA(O_RD_B_DATA),
        .O_INDEX_R0(O_INDEX_R0), .I_SYS_SEL(I_SYS_SEL), .I_SYS_WE(I_SYS_WE),
        .I_SYS_WDATA(I_SYS_WDATA), .O_SYS_RDATA(O_SYS_RDATA), .I_PC_WE(1'b0),
        .I_PC_NEXT(32'h0000_0000), .I_CTL_SEL(I_CTL_SEL), .I_CTL_WE(I_CTL_WE),
        .I_CTL_RE(I_CTL_RE), .I_CTL_WDATA(I_CTL_WDATA), .O_CTL_RDATA(O_CTL_RDATA),
        .O_PRIV_FAULT(O_PRIV_FAULT), .I_EXC_TAKE(I_EXC_TAKE), .I_EXC_SR(I_EXC_SR),
        .I_EXC_PC(I_EXC_PC), .I_EXC_RETURN(I_EXC_RETURN), .O_PC(O_PC),
        .O_STATUS(O_STATUS), .O_VBR(O_VBR), .O_GBR(O_GBR));

    // Compare one value, count it, report a mismatch at once
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Counts, verdict, end of run
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Watchdog: a hang counts as a mismatch
    always @(posedge I_MCLK) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            num_errors++;
            close_out();
        end
    end

    // Reset values of the architectural state
    task automatic t_reset();
        check("status", O_STATUS, SR_RESET);
        check("vbr", O_VBR, VBR_RESET);
    endtask

    // Bank one active at reset, then switch banks through the status word
    task automatic t_banks();
        i_cpu_decoder_model.gpr_wr(4'h0, 32'h1111_aaaa, 1'b0);
        i_cpu_decoder_model.gpr_wr(4'h8, 32'h8888_0008, 1'b0);
        i_cpu_decoder_model.ctl(CTL_ALT_R0, 1'b0, 32'h0);
        check("other bank r0", O_CTL_RDATA, ZERO_WORD);
        i_cpu_decoder_model.rd(4'h0, 4'h8, 1'b0);
        check("r0 bank one", O_RD_A_DATA, 32'h1111_aaaa);
        check("index r0", O_INDEX_R0, 32'h1111_aaaa);
        i_cpu_decoder_model.ctl(CTL_STATUS, 1'b1, 32'hdfff_ffff);
        check("masked status", O_STATUS, 32'h5000_03f3);
        i_cpu_decoder_model.rd(4'h0, 4'h8, 1'b0);
        check("r0 bank zero", O_RD_A_DATA, ZERO_WORD);
        check("shared r8", O_RD_B_DATA, 32'h8888_0008);
        check("index r0 bank zero", O_INDEX_R0, ZERO_WORD);
        i_cpu_decoder_model.ctl(CTL_ALT_R0, 1'b0, 32'h0);
        check("other bank r0", O_CTL_RDATA, 32'h1111_aaaa);
    endtask

    // Register-zero-only slot ignores the given numbers on port A and write
    task automatic t_r0_only();
        i_cpu_decoder_model.gpr_wr(4'h5, 32'h0000_beef, 1'b1);
        i_cpu_decoder_model.rd(4'h5, 4'h5, 1'b1);
        check("forced r0", O_RD_A_DATA, 32'h0000_beef);
        check("r5 untouched", O_RD_B_DATA, ZERO_WORD);
    endtask

    // Every system register loads and reads back
    task automatic t_sys();
        sys_sel_t s;
        for (int k = 0; k < 4; k++) begin
            s = sys_sel_t'(k);
            i_cpu_decoder_model.sys_wr(s, 32'h5500_0010 + 32'(k));
            i_cpu_decoder_model.sys_wr(s, 32'h5500_0010 + 32'(k));
            check("system reg", O_SYS_RDATA, 32'h5500_0010 + 32'(k));
        end
    endtask

    // Exception entry saves counter and status together, return restores them
    task automatic t_exc();
        i_cpu_decoder_model.exc_take(32'hffff_ffff, 32'h0000_0600);
        check("handler pc", O_PC, 32'h0000_0600);
        check("new status", O_STATUS, SR_VALID_MASK);
        i_cpu_decoder_model.ctl(CTL_SAVED_RET, 1'b0, 32'h0);
        check("saved pc", O_CTL_RDATA, 32'h5500_0013);
        i_cpu_decoder_model.ctl(CTL_SAVED_STAT, 1'b0, 32'h0);
        check("saved status", O_CTL_RDATA, 32'h5000_03f3);
        i_cpu_decoder_model.exc_ret();
        check("return pc", O_PC, 32'h5500_0013);
        check("return status", O_STATUS, 32'h5000_03f3);
    endtask

    // User mode: privileged registers refused, global base allowed, bank zero used
    task automatic t_user();
        i_cpu_decoder_model.ctl(CTL_STATUS, 1'b1, 32'h0000_00f0);
        i_cpu_decoder_model.ctl(CTL_VECTOR, 1'b1, 32'h0000_4000);
        check("fault", {31'h0, O_PRIV_FAULT}, 32'h1);
        check("refused rdata", O_CTL_RDATA, ZERO_WORD);
        check("vbr kept", O_VBR, VBR_RESET);
        i_cpu_decoder_model.ctl(CTL_GLOBAL, 1'b1, 32'h00c0_ffee);
        check("no fault", {31'h0, O_PRIV_FAULT}, 32'h0);
        check("gbr", O_GBR, 32'h00c0_ffee);
        i_cpu_decoder_model.rd(4'h0, 4'h8, 1'b0);
        check("user r0", O_RD_A_DATA, 32'h0000_beef);
    endtask

    // Reset again in mid-run: state returns to its reset values, then runs on
    task automatic t_rereset();
        @(posedge I_MCLK);
        I_ARST_N <= 1'b0;
        @(posedge I_MCLK);
        #1;
        t_reset();
        check("gbr reset", O_GBR, GBR_RESET);
        check("r0 reset", O_INDEX_R0, ZERO_WORD);
        @(posedge I_MCLK);
        I_ARST_N <= 1'b1;
        i_cpu_decoder_model.rd(4'h0, 4'h8, 1'b0);
        check("r0 after rereset", O_RD_A_DATA, ZERO_WORD);
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge I_MCLK);
        #1;
        t_reset();
        @(posedge I_MCLK);
        I_ARST_N <= 1'b1;
        t_banks();
        t_r0_only();
        t_sys();
        t_exc();
        t_user();
        t_rereset();
        close_out();
    end
endmodule
